// ===== uhs_hub_status.v
`include "uhs_map.vh"

module uhs_hub_status (
	input wire I_CLK,
	input wire I_RST_N,
	input wire I_HSI_PIN,
	input wire I_ASI_PIN,
	input wire I_FIXED_PORT_STRAP1,
	input wire I_CFG_SEL0,
	input wire I_SPEED_VALID,
	input wire I_LINK_HS,
	input wire I_CONFIGURED,
	input wire I_SUSPENDED,
	output wire O_HISPEED_LINK_INDICATOR,
	output wire O_HISPEED_LINK_INDICATOR_OE_N,
	output wire O_ACTIVE_SUSPEND_INDICATOR,
	output wire O_ACTIVE_SUSPEND_INDICATOR_OE_N,
	output wire [1:0] O_CFG_METHOD,
	output wire [3:0] O_FIXED_PORT_MASK,
	output wire O_SELF_POWERED,
	output wire O_STRAPS_VALID
);

	// Synchroniser bank and the place of each pin inside it.
	localparam PIN_COUNT = 4;
	localparam SYNC_DEPTH = `UHS_SYNC_DEPTH;
	localparam PIN_HSI = 0;
	localparam PIN_ASI = 1;
	localparam PIN_FIX1 = 2;
	localparam PIN_CFG0 = 3;

	// One-hot sequence from reset release to driving the shared pins.
	localparam [2:0] ST_WAIT = 3'h1;
	localparam [2:0] ST_SETTLE = 3'h2;
	localparam [2:0] ST_DRIVE = 3'h4;

	wire [PIN_COUNT-1:0] pin_raw;
	wire [PIN_COUNT-1:0] pin_sync;
	wire captured;
	wire hs_on;
	wire act_on;
	wire hs_pol;
	wire act_pol;

	reg [2:0] state_q;
	reg [2:0] state_d;
	reg [1:0] cfg_q;
	reg [1:0] cfg_d;
	reg [1:0] fix_q;
	reg [1:0] fix_d;
	reg [3:0] mask_q;
	reg [3:0] mask_d;
	reg [3:0] mask_dec;
	reg oe_n_q;
	reg oe_n_d;
	reg hsi_out_q;
	reg hsi_out_d;
	reg asi_out_q;
	reg asi_out_d;

	assign pin_raw[PIN_HSI] = I_HSI_PIN;
	assign pin_raw[PIN_ASI] = I_ASI_PIN;
	assign pin_raw[PIN_FIX1] = I_FIXED_PORT_STRAP1;
	assign pin_raw[PIN_CFG0] = I_CFG_SEL0;

	// The synchronisers carry no reset, so they still hold the strap level at release.
	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_sync
			reg [SYNC_DEPTH-1:0] stage_q;

			always @(posedge I_CLK) begin
				stage_q <= {stage_q[SYNC_DEPTH-2:0], pin_raw[gi]};
			end

			assign pin_sync[gi] = stage_q[SYNC_DEPTH-1];
		end
	endgenerate

	// The straps are taken once, on the first edge after reset release.
	always @* begin
		case (state_q)
			ST_WAIT: begin
				state_d = ST_SETTLE;
			end
			ST_SETTLE: begin
				state_d = ST_DRIVE;
			end
			ST_DRIVE: begin
				state_d = ST_DRIVE;
			end
			default: begin
				state_d = ST_WAIT;
			end
		endcase
	end

	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_q <= ST_WAIT;
		end else begin
			state_q <= state_d;
		end
	end

	assign captured = (state_q == ST_SETTLE) | (state_q == ST_DRIVE);

	always @* begin
		case ({pin_sync[PIN_FIX1], pin_sync[PIN_ASI]})
			`UHS_FIX_NONE: mask_dec = `UHS_MASK_NONE;
			`UHS_FIX_P1: mask_dec = `UHS_MASK_P1;
			`UHS_FIX_P12: mask_dec = `UHS_MASK_P12;
			`UHS_FIX_P123: mask_dec = `UHS_MASK_P123;
			default: mask_dec = `UHS_MASK_NONE;
		endcase
	end

	always @* begin
		if (state_q == ST_WAIT) begin
			cfg_d = {pin_sync[PIN_HSI], pin_sync[PIN_CFG0]};
			fix_d = {pin_sync[PIN_FIX1], pin_sync[PIN_ASI]};
			mask_d = mask_dec;
		end else begin
			cfg_d = cfg_q;
			fix_d = fix_q;
			mask_d = mask_q;
		end
	end

	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			cfg_q <= 2'h0;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			fix_q <= 2'h0;
		end else begin
			fix_q <= fix_d;
		end
	end

	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			mask_q <= `UHS_MASK_NONE;
		end else begin
			mask_q <= mask_d;
		end
	end

	// Before capture the polarity comes straight from the pin, so the first level is negated.
	assign hs_pol = captured ? cfg_q[`UHS_CFG_BIT_HI] : pin_sync[PIN_HSI];
	assign act_pol = captured ? fix_q[0] : pin_sync[PIN_ASI];
	assign hs_on = captured & I_SPEED_VALID & I_LINK_HS;
	assign act_on = captured & I_CONFIGURED & ~I_SUSPENDED;

	always @* begin
		oe_n_d = captured ? `UHS_OE_DRIVE : `UHS_OE_RELEASE;
		hsi_out_d = hs_on ^ hs_pol;
		asi_out_d = act_on ^ act_pol;
	end

	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			oe_n_q <= `UHS_OE_RELEASE;
		end else begin
			oe_n_q <= oe_n_d;
		end
	end

	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			hsi_out_q <= 1'b0;
		end else begin
			hsi_out_q <= hsi_out_d;
		end
	end

	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			asi_out_q <= 1'b0;
		end else begin
			asi_out_q <= asi_out_d;
		end
	end

	assign O_HISPEED_LINK_INDICATOR = hsi_out_q;
	assign O_HISPEED_LINK_INDICATOR_OE_N = oe_n_q;
	assign O_ACTIVE_SUSPEND_INDICATOR = asi_out_q;
	assign O_ACTIVE_SUSPEND_INDICATOR_OE_N = oe_n_q;
	assign O_CFG_METHOD = cfg_q;
	assign O_FIXED_PORT_MASK = mask_q;
	assign O_SELF_POWERED = fix_q[0];
	assign O_STRAPS_VALID = captured;

endmodule // uhs_hub_status

// ===== uhs_map.vh
`ifndef UHS_MAP_VH
`define UHS_MAP_VH

// Output enable levels of the shared indicator/strap pins (enable is active low).
`define UHS_OE_DRIVE 1'b0
`define UHS_OE_RELEASE 1'b1

// Strap value that selects an active high indicator.
`define UHS_POL_ACTIVE_HIGH 1'b0

// Fixed-port strap codes.
`define UHS_FIX_NONE 2'h0
`define UHS_FIX_P1 2'h1
`define UHS_FIX_P12 2'h2
`define UHS_FIX_P123 2'h3

// Fixed-port masks, bit n set when port n+1 has a permanently attached device.
`define UHS_MASK_NONE 4'h0
`define UHS_MASK_P1 4'h1
`define UHS_MASK_P12 4'h3
`define UHS_MASK_P123 4'h7

// Bit positions inside the latched configuration-method code.
`define UHS_CFG_BIT_LO 0
`define UHS_CFG_BIT_HI 1

// Synchroniser depth for pin inputs.
`define UHS_SYNC_DEPTH 2

`endif

// ===== uhs_hub_status_sva.sv
module uhs_hub_status_sva (
	input wire I_CLK, I_RST_N, I_SPEED_VALID, I_LINK_HS, I_CONFIGURED, I_SUSPENDED,
	input wire O_HISPEED_LINK_INDICATOR, O_HISPEED_LINK_INDICATOR_OE_N, O_STRAPS_VALID,
	input wire O_ACTIVE_SUSPEND_INDICATOR, O_ACTIVE_SUSPEND_INDICATOR_OE_N, O_SELF_POWERED,
	input wire [1:0] O_CFG_METHOD,
	input wire [3:0] O_FIXED_PORT_MASK
);
	wire h = O_HISPEED_LINK_INDICATOR, hn = O_HISPEED_LINK_INDICATOR_OE_N, v = O_STRAPS_VALID;
	wire a = O_ACTIVE_SUSPEND_INDICATOR, an = O_ACTIVE_SUSPEND_INDICATOR_OE_N;
	wire hon = I_SPEED_VALID & I_LINK_HS, aon = I_CONFIGURED & ~I_SUSPENDED;
	// The active indicator polarity is strap bit 0, recovered from the decoded mask.
	wire ph = O_CFG_METHOD[1], pa = ^O_FIXED_PORT_MASK[2:0];
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	a_hs_level: assert property (!hn |-> h == ($past(hon) ^ ph)) else $error("hs level");
	a_act_level: assert property (!an |-> a == ($past(aon) ^ pa)) else $error("act level");
	a_valid_time: assert property ($rose(I_RST_N) |=> v) else $error("valid late");
	a_start_off: assert property ($rose(v) |-> hn && an && h == ph && a == pa) else $error("start");
	a_then_drive: assert property ($rose(v) |=> !hn && !an) else $error("no drive");
	a_drive_hold: assert property (!hn |=> !hn && !an && v) else $error("drive lost");
	a_strap_hold: assert property (v |=> $stable({O_CFG_METHOD, O_FIXED_PORT_MASK, O_SELF_POWERED}))
		else $error("strap moved");
	a_mask_code: assert property (v |-> O_FIXED_PORT_MASK inside {4'h0, 4'h1, 4'h3, 4'h7}) else $error("mask");
endmodule // uhs_hub_status_sva

bind uhs_hub_status uhs_hub_status_sva uhs_hub_status_sva_inst (.*);

// ===== uhs_board.sv
module uhs_board (
	input wire O_HISPEED_LINK_INDICATOR, O_HISPEED_LINK_INDICATOR_OE_N,
	input wire O_ACTIVE_SUSPEND_INDICATOR, O_ACTIVE_SUSPEND_INDICATOR_OE_N,
	input wire [3:0] sp,
	output wire I_HSI_PIN, I_ASI_PIN, I_FIXED_PORT_STRAP1, I_CFG_SEL0
);
	timeunit 1ns;
	timeprecision 1ns;
	// A released pin falls back to the level of its strap resistor.
	assign I_HSI_PIN = O_HISPEED_LINK_INDICATOR_OE_N ? sp[0] : O_HISPEED_LINK_INDICATOR;
	assign I_ASI_PIN = O_ACTIVE_SUSPEND_INDICATOR_OE_N ? sp[1] : O_ACTIVE_SUSPEND_INDICATOR;
	assign {I_CFG_SEL0, I_FIXED_PORT_STRAP1} = sp[3:2];
endmodule // uhs_board

// ===== uhs_hub_status_test.sv
module uhs_hub_status_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic I_CLK = 0, I_RST_N = 0, I_SPEED_VALID, I_LINK_HS, I_CONFIGURED, I_SUSPENDED;
	wire I_HSI_PIN, I_ASI_PIN, I_FIXED_PORT_STRAP1, I_CFG_SEL0, O_SELF_POWERED, O_STRAPS_VALID;
	wire O_HISPEED_LINK_INDICATOR, O_HISPEED_LINK_INDICATOR_OE_N;
	wire O_ACTIVE_SUSPEND_INDICATOR, O_ACTIVE_SUSPEND_INDICATOR_OE_N;
	wire [1:0] O_CFG_METHOD;
	wire [3:0] O_FIXED_PORT_MASK;
	logic [3:0] sp, l;
	logic [11:0] q[$];
	int miscompares = 0, tests_run = 0, hold = 6;
	event look;
	always #10 I_CLK = ~I_CLK;
	uhs_hub_status uhs_hub_status_inst (.*);
	uhs_board uhs_board_inst (.*);
	task automatic chk(logic [11:0] g, logic [11:0] e);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task end_sim;
		if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Expected {valid, method, mask, self power, hs, hs oe, act, act oe}; drive starts on edge 2.
	function automatic logic [11:0] exp_of(logic [3:0] p, logic up);
		logic h, a;
		h = up & I_SPEED_VALID & I_LINK_HS;
		a = up & I_CONFIGURED & ~I_SUSPENDED;
		return {1'b1, p[0], p[3], (4'h1 << {p[2], p[1]}) - 4'h1, p[1], h ^ p[0], !up, a ^ p[1], !up};
	endfunction
	always @(look) chk({O_STRAPS_VALID, O_CFG_METHOD, O_FIXED_PORT_MASK, O_SELF_POWERED,
		O_HISPEED_LINK_INDICATOR,
		O_HISPEED_LINK_INDICATOR_OE_N, O_ACTIVE_SUSPEND_INDICATOR, O_ACTIVE_SUSPEND_INDICATOR_OE_N},
		q.pop_front());
	initial begin
		void'($urandom(9));
		{I_SPEED_VALID, I_LINK_HS, I_CONFIGURED, I_SUSPENDED} = $urandom;
		repeat (8) begin
			I_RST_N = 0;
			sp = $urandom;
			l = sp;
			repeat (hold) @(posedge I_CLK);
			hold = 50;
			#1 q.push_back(12'h005);
			-> look;
			I_RST_N = 1;
			for (int n = 1; n < 8; n++) begin
				@(posedge I_CLK);
				#1 q.push_back(exp_of(l, n > 1));
				-> look;
				{I_SPEED_VALID, I_LINK_HS, I_CONFIGURED, I_SUSPENDED} = $urandom;
				sp = $urandom;
			end
		end
		end_sim;
	end
	initial begin
		#20000 miscompares++;
		end_sim;
	end
endmodule // uhs_hub_status_test
